/* logic/cia_pkg.sv */
/*
  Shared constants and types for the core interrupt sequencer and the
  operand address former. Assumes one core clock and a core that steps
  instructions on a one-cycle instruction-cycle enable.
*/
// Function
// - Finish current instruction before interrupt entry
// - Entry stacks PC, then jumps to vector
// - Entry sequence takes exactly five cycles
// - Interrupt exit pops PC, sets mask
// - Priority pin, watchdog, multifunction, trap
// - Mask gates hardware sources, not trap
// - Software trap always enters the handler
// - Trap entry stacks PC, clears mask
// - Indexed adds 8-bit offset to pointer
// - Indirect uses pointer within data space
// - Direct takes 8-bit data address field
// - Immediate takes 8-bit operand field
// - Inherent fetches no operand bytes
// - Absolute builds 11-bit target, two bytes
// - Short jump reaches -31 to +32
// - Masked requests wait, execution continues
// - Pointer bit 11 selects address space when indexed
// - Push subtracts two, pull adds two
package cia_pkg;

  localparam int PC_W   = 11;
  localparam int ADDR_W = 12;

  // -------------------------------------------------------------------
  // Stack
  // -------------------------------------------------------------------
  localparam logic [3:0] SP_RST     = 4'hF;
  localparam logic [3:0] SP_STEP    = 4'h2;
  localparam logic [3:0] SP_ONE     = 4'h1;
  localparam logic [7:0] STACK_PAGE = 8'h03;

  // -------------------------------------------------------------------
  // Vectors, low byte at the even address
  // -------------------------------------------------------------------
  localparam logic [11:0] VEC_WDT  = 12'hFF6;
  localparam logic [11:0] VEC_MFT  = 12'hFF8;
  localparam logic [11:0] VEC_PIN  = 12'hFFA;
  localparam logic [11:0] VEC_TRAP = 12'hFFC;

  // -------------------------------------------------------------------
  // Addressing
  // -------------------------------------------------------------------
  localparam logic [3:0]  DATA_PAGE  = 4'h0;
  localparam logic [10:0] REL_BIAS   = 11'h001;
  localparam logic [10:0] REL_MAX_FW = 11'h020;
  localparam logic [10:0] REL_MAX_BK = 11'h7E1;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_PUSH_LO  = 4'h1,
    ST_PUSH_HI  = 4'h2,
    ST_VEC_LO   = 4'h3,
    ST_VEC_HI   = 4'h4,
    ST_JUMP     = 4'h5,
    ST_POP_HI   = 4'h6,
    ST_POP_LO   = 4'h7,
    ST_POP_CAP  = 4'h8,
    ST_POP_WAIT = 4'h9,
    ST_POP_LOAD = 4'hA
  } cia_state_t;

  typedef enum logic [1:0] {
    SRC_TRAP = 2'h0,
    SRC_MFT  = 2'h1,
    SRC_WDT  = 2'h2,
    SRC_PIN  = 2'h3
  } cia_src_t;

  typedef enum logic [2:0] {
    AM_INDEXED   = 3'h0,
    AM_INDIRECT  = 3'h1,
    AM_DIRECT    = 3'h2,
    AM_IMMEDIATE = 3'h3,
    AM_INHERENT  = 3'h4,
    AM_ABSOLUTE  = 3'h5,
    AM_RELATIVE  = 3'h6
  } cia_mode_t;

endpackage

/* logic/cia_addr.sv */
/*
  Operand address former: effective address, immediate operand and
  operand byte count for the current addressing mode, registered.
  Assumes operand bytes and pointer are stable while mode is valid.
*/
module cia_addr
  import cia_pkg::*;
(
  input  wire logic       clk,        // Core clock
  input  wire logic       reset_n,    // Async reset, active low
  input  wire cia_mode_t  mode,       // Addressing mode
  input  wire logic [11:0] x_ptr,     // Pointer register
  input  wire logic [7:0] op_a,       // First operand byte
  input  wire logic [7:0] op_b,       // Second operand byte
  input  wire logic [10:0] pc,        // Current program counter
  output logic [11:0]     ea,         // Effective address
  output logic [7:0]      imm,        // Immediate operand
  output logic [1:0]      opnd_bytes  // Operand bytes to fetch
);

  logic [10:0] idx_sum;
  logic [10:0] rel_tgt;
  logic [11:0] next_ea;
  logic [7:0]  next_imm;
  logic [1:0]  next_bytes;

  assign idx_sum = x_ptr[10:0] + {3'h0, op_a};
  // Field is a 6-bit signed value biased by one: -31..+32
  assign rel_tgt = pc + {{5{op_a[5]}}, op_a[5:0]} + REL_BIAS;

  always_comb begin
    next_ea    = 12'h000;
    next_imm   = 8'h00;
    next_bytes = 2'h0;
    unique case (mode)
      AM_INDEXED: begin
        next_ea    = x_ptr[11] ? {1'b1, idx_sum}
                               : {DATA_PAGE, idx_sum[7:0]};
        next_bytes = 2'h1;
      end
      AM_INDIRECT:  next_ea = {DATA_PAGE, x_ptr[7:0]};
      AM_DIRECT: begin
        next_ea    = {DATA_PAGE, op_a};
        next_bytes = 2'h1;
      end
      AM_IMMEDIATE: begin
        next_imm   = op_a;
        next_bytes = 2'h1;
      end
      AM_INHERENT:  next_bytes = 2'h0;
      AM_ABSOLUTE: begin
        next_ea    = {1'b1, op_a[2:0], op_b};
        next_bytes = 2'h2;
      end
      AM_RELATIVE:  next_ea = {1'b1, rel_tgt};
      default:      next_bytes = 2'h0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ea         <= 12'h000;
      imm        <= 8'h00;
      opnd_bytes <= 2'h0;
    end else begin
      ea         <= next_ea;
      imm        <= next_imm;
      opnd_bytes <= next_bytes;
    end
  end

  a_rel_reach: assert property (
    @(posedge clk) disable iff (!reset_n)
    mode == AM_RELATIVE |=>
      ((ea[10:0] - $past(pc)) <= REL_MAX_FW ||
       (ea[10:0] - $past(pc)) >= REL_MAX_BK))
    else $error("short jump target out of reach");

  a_index_data: assert property (
    @(posedge clk) disable iff (!reset_n)
    (mode == AM_INDEXED && !x_ptr[11]) |=>
      ea[11:8] == DATA_PAGE)
    else $error("indexed data access left data space");

endmodule

/* logic/cia_core.sv */
/*
  Interrupt sequencer of the core: mask bit, request arbitration,
  five-cycle entry through the stack and vector table, and the five-
  cycle return for both exit instructions. Also hosts the operand
  address former. Assumes requests come from same-clock peripherals,
  cycle_en marks instruction cycles, and memory read data is valid by
  the next cycle_en after a read strobe and then holds.
*/
module cia_core
  import cia_pkg::*;
(
  input  wire logic        clk,          // Core clock, 100 MHz
  input  wire logic        reset_n,      // Async reset, active low
  input  wire logic        cycle_en,     // Instruction cycle enable
  input  wire logic        instr_done,   // Last cycle of instruction
  input  wire logic        op_trap,      // software_trap_op finishing
  input  wire logic        op_iret,      // interrupt_exit_op finishing
  input  wire logic        op_sret,      // subroutine_exit_op finish
  input  wire logic        pin_wake_irq, // Pin wake-up request
  input  wire logic        watchdog_timer_irq,      // Watchdog req
  input  wire logic        multifunction_timer_irq, // Timer request
  input  wire logic        mask_wr,      // Software writes mask bit
  input  wire logic        mask_wdata,   // Value written to mask bit
  input  wire logic [10:0] pc_in,        // Current program counter
  input  wire logic [7:0]  mem_rdata,    // Memory read data
  input  wire cia_mode_t   mode,         // Addressing mode
  input  wire logic [11:0] x_ptr,        // Pointer register
  input  wire logic [7:0]  op_a,         // First operand byte
  input  wire logic [7:0]  op_b,         // Second operand byte
  output logic             seq_busy,     // Sequencer owns fetch
  output logic [11:0]      mem_addr,     // Stack or vector address
  output logic             mem_rd,       // Read strobe
  output logic             mem_wr,       // Write strobe
  output logic [7:0]       mem_wdata,    // Stack write data
  output logic             pc_load,      // Load new PC, one pulse
  output logic [10:0]      pc_load_value,// New PC value
  output logic             global_mask,  // Mask bit of status
  output logic [3:0]       stack_ptr,    // Stack pointer
  output cia_src_t         active_src,   // Source being entered
  output logic [11:0]      ea,           // Effective address
  output logic [7:0]       imm,          // Immediate operand
  output logic [1:0]       opnd_bytes    // Operand bytes to fetch
);

  cia_state_t  state;
  cia_state_t  next_state;
  cia_src_t    next_src;
  logic        trap_pend;
  logic        is_iret;
  logic [10:0] ret_pc;
  logic [7:0]  byte_lo;
  logic        boundary;
  logic        hw_ok;
  logic        take_entry;
  logic [11:0] vec_base;
  logic [2:0]  entry_cnt;

  // -------------------------------------------------------------------
  // Arbitration
  // -------------------------------------------------------------------
  // only at instruction end
  assign boundary = (state == ST_IDLE) && cycle_en && instr_done;

  assign hw_ok = global_mask && (pin_wake_irq || watchdog_timer_irq ||
                                 multifunction_timer_irq);

  assign take_entry = hw_ok || op_trap || trap_pend;

  always_comb begin
    next_src = SRC_TRAP;
    if (hw_ok && pin_wake_irq) begin
      next_src = SRC_PIN;
    end else if (hw_ok && watchdog_timer_irq) begin
      next_src = SRC_WDT;
    end else if (hw_ok && multifunction_timer_irq) begin
      next_src = SRC_MFT;
    end
  end

  always_comb begin
    unique case (active_src)
      SRC_PIN:  vec_base = VEC_PIN;
      SRC_WDT:  vec_base = VEC_WDT;
      SRC_MFT:  vec_base = VEC_MFT;
      SRC_TRAP: vec_base = VEC_TRAP;
    endcase
  end

  // -------------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (boundary) begin
          if (op_iret || op_sret) begin
            next_state = ST_POP_HI;
          end else if (take_entry) begin
            next_state = ST_PUSH_LO;
          end
        end
      end
      ST_PUSH_LO:  next_state = ST_PUSH_HI;
      ST_PUSH_HI:  next_state = ST_VEC_LO;
      ST_VEC_LO:   next_state = ST_VEC_HI;
      ST_VEC_HI:   next_state = ST_JUMP;
      ST_JUMP:     next_state = ST_IDLE;
      ST_POP_HI:   next_state = ST_POP_LO;
      ST_POP_LO:   next_state = ST_POP_CAP;
      ST_POP_CAP:  next_state = ST_POP_WAIT;
      ST_POP_WAIT: next_state = ST_POP_LOAD;
      ST_POP_LOAD: next_state = ST_IDLE;
      default:     next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
    end else if (cycle_en) begin
      state <= next_state;
    end
  end

  assign seq_busy = (state != ST_IDLE);

  // Trap waits if a hardware source wins the same boundary
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trap_pend <= 1'b0;
    end else if (boundary && op_trap && hw_ok) begin
      trap_pend <= 1'b1;
    end else if (boundary && !hw_ok && next_state == ST_PUSH_LO) begin
      trap_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      active_src <= SRC_TRAP;
      ret_pc     <= 11'h000;
      is_iret    <= 1'b0;
    end else if (boundary) begin
      active_src <= next_src;
      ret_pc     <= pc_in;
      is_iret    <= op_iret;
    end
  end

  // -------------------------------------------------------------------
  // Memory port
  // -------------------------------------------------------------------
  // stack return, then vector
  always_comb begin
    mem_addr = 12'h000;
    unique case (state)
      ST_PUSH_LO: mem_addr = {STACK_PAGE, stack_ptr};
      ST_PUSH_HI: mem_addr = {STACK_PAGE, 4'(stack_ptr - SP_ONE)};
      ST_VEC_LO:  mem_addr = vec_base;
      ST_VEC_HI:  mem_addr = vec_base | 12'h001;
      ST_POP_HI:  mem_addr = {STACK_PAGE, 4'(stack_ptr + SP_ONE)};
      ST_POP_LO:  mem_addr = {STACK_PAGE, 4'(stack_ptr + SP_STEP)};
      default:    mem_addr = 12'h000;
    endcase
  end

  assign mem_wr = cycle_en &&
                  (state == ST_PUSH_LO || state == ST_PUSH_HI);
  assign mem_rd = cycle_en &&
                  (state == ST_VEC_LO || state == ST_VEC_HI ||
                   state == ST_POP_HI || state == ST_POP_LO);

  // Low byte goes first, like a subroutine call
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_wdata <= 8'h00;
    end else if (boundary) begin
      mem_wdata <= pc_in[7:0];
    end else if (cycle_en && state == ST_PUSH_LO) begin
      mem_wdata <= {5'h00, ret_pc[10:8]};
    end
  end

  // -------------------------------------------------------------------
  // Stack pointer
  // -------------------------------------------------------------------
  // two per address
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stack_ptr <= SP_RST;
    end else if (cycle_en && state == ST_PUSH_HI) begin
      stack_ptr <= 4'(stack_ptr - SP_STEP);
    end else if (cycle_en && state == ST_POP_LOAD) begin
      stack_ptr <= 4'(stack_ptr + SP_STEP);
    end
  end

  // -------------------------------------------------------------------
  // New program counter
  // -------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      byte_lo <= 8'h00;
    end else if (cycle_en && state == ST_VEC_HI) begin
      byte_lo <= mem_rdata;
    end else if (cycle_en && state == ST_POP_LO) begin
      byte_lo <= mem_rdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_load       <= 1'b0;
      pc_load_value <= 11'h000;
    end else begin
      pc_load <= 1'b0;
      if (cycle_en && state == ST_JUMP) begin
        pc_load       <= 1'b1;
        pc_load_value <= {mem_rdata[2:0], byte_lo};
      end else if (cycle_en && state == ST_POP_CAP) begin
        pc_load_value <= {byte_lo[2:0], mem_rdata};
      end else if (cycle_en && state == ST_POP_LOAD) begin
        pc_load <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------
  // Mask bit
  // -------------------------------------------------------------------
  // Sequencer wins over a software write in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      global_mask <= 1'b0;
    end else if (cycle_en && state == ST_JUMP) begin
      global_mask <= 1'b0;
    end else if (cycle_en && state == ST_POP_LOAD && is_iret) begin
      global_mask <= 1'b1;
    end else if (mask_wr) begin
      global_mask <= mask_wdata;
    end
  end

  // -------------------------------------------------------------------
  // Operand addressing
  // -------------------------------------------------------------------
  cia_addr u_addr (
    .clk        (clk),
    .reset_n    (reset_n),
    .mode       (mode),
    .x_ptr      (x_ptr),
    .op_a       (op_a),
    .op_b       (op_b),
    .pc         (pc_in),
    .ea         (ea),
    .imm        (imm),
    .opnd_bytes (opnd_bytes)
  );

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Counts instruction cycles spent in entry
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      entry_cnt <= 3'h0;
    end else if (state == ST_IDLE) begin
      entry_cnt <= 3'h0;
    end else if (cycle_en && state <= ST_JUMP) begin
      entry_cnt <= 3'(entry_cnt + 3'h1);
    end
  end

  a_start_boundary: assert property (
    ($past(state) == ST_IDLE && state != ST_IDLE) |->
      $past(instr_done && cycle_en))
    else $error("sequence began mid instruction");

  a_push_return: assert property (
    (state == ST_PUSH_LO && cycle_en) |->
      mem_wr && mem_wdata == ret_pc[7:0] &&
      mem_addr == {STACK_PAGE, stack_ptr})
    else $error("return address low byte not stacked");

  a_entry_length: assert property (
    (state == ST_JUMP && cycle_en) |-> entry_cnt == 3'h4
      ##1 pc_load)
    else $error("entry did not take five cycles");

  a_exit_mask: assert property (
    (state == ST_POP_LOAD && cycle_en && is_iret) |=>
      global_mask && pc_load)
    else $error("interrupt exit left mask clear");

  a_pin_first: assert property (
    (boundary && global_mask && pin_wake_irq &&
     !op_iret && !op_sret) |=>
      state == ST_PUSH_LO && active_src == SRC_PIN)
    else $error("pin wake-up not given top priority");

  a_masked_wait: assert property (
    (boundary && !global_mask && !op_trap && !trap_pend &&
     !op_iret && !op_sret) |=> state == ST_IDLE)
    else $error("masked request was taken");

  a_trap_unmasked: assert property (
    (boundary && op_trap && !hw_ok && !op_iret && !op_sret) |=>
      state == ST_PUSH_LO && active_src == SRC_TRAP)
    else $error("software trap did not enter");

  a_entry_clears: assert property (
    (state == ST_JUMP && cycle_en) |=> !global_mask)
    else $error("entry left mask set");

  a_push_step: assert property (
    (state == ST_PUSH_HI && cycle_en) |=>
      stack_ptr == 4'($past(stack_ptr) - SP_STEP))
    else $error("stack pointer not lowered by two");

endmodule

/* bench/cia_mem_model.sv */
/*
  Memory partner of the interrupt sequencer: stack RAM and vector
  table in one byte array. Assumes one-clock read and write strobes
  on the core clock; read data holds until the next read.
*/
module cia_mem_model (
  input  wire logic        clk,       // Core clock
  input  wire logic [11:0] mem_addr,  // Byte address
  input  wire logic        mem_rd,    // Read strobe
  input  wire logic        mem_wr,    // Write strobe
  input  wire logic [7:0]  mem_wdata, // Write data
  output logic      [7:0]  mem_rdata  // Read data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [0:4095];

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  // Address pattern, so vector targets differ and are predictable
  initial begin
    for (int a = 0; a < 4096; a++) begin
      mem[a] = 8'(a) ^ 8'h3C;
    end
    mem_rdata = 8'h00;
  end

  always @(posedge clk) begin
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
    if (mem_rd) begin
      mem_rdata <= mem[mem_addr];
    end
  end
endmodule

/* bench/tb.sv */
/*
  Self-checking bench for the interrupt sequencer and address former.
  Assumes the memory partner model and the shared package; inputs are
  driven at the falling clock edge.
*/
module tb
  import cia_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, reset_n, cycle_en, instr_done;
  logic        op_trap, op_iret, op_sret, mask_wr, mask_wdata;
  logic [2:0]  irq_v;
  logic [10:0] pc_in, pc_load_value, lv;
  logic [7:0]  mem_rdata, op_a, op_b, mem_wdata, imm;
  logic [11:0] x_ptr, mem_addr, ea, e;
  logic        seq_busy, mem_rd, mem_wr, pc_load, global_mask;
  logic [3:0]  stack_ptr;
  logic [1:0]  opnd_bytes;
  cia_mode_t   mode;
  cia_src_t    active_src;
  int          error_cnt, n_checks, n_cyc, load_at, cyc, seed;
  int          g, sp, pend, nb;
  logic [10:0] stk[$];

  cia_core i_cia_core (.clk(clk), .reset_n(reset_n),
    .cycle_en(cycle_en), .instr_done(instr_done), .op_trap(op_trap),
    .op_iret(op_iret), .op_sret(op_sret), .pin_wake_irq(irq_v[2]),
    .watchdog_timer_irq(irq_v[1]), .multifunction_timer_irq(irq_v[0]),
    .mask_wr(mask_wr), .mask_wdata(mask_wdata), .pc_in(pc_in),
    .mem_rdata(mem_rdata), .mode(mode), .x_ptr(x_ptr), .op_a(op_a),
    .op_b(op_b), .seq_busy(seq_busy), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .pc_load(pc_load), .pc_load_value(pc_load_value),
    .global_mask(global_mask), .stack_ptr(stack_ptr),
    .active_src(active_src), .ea(ea), .imm(imm),
    .opnd_bytes(opnd_bytes));

  cia_mem_model i_cia_mem_model (.clk(clk), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));

  // ------------------------------------------------------------------
  // Clock, watchdog, monitor
  // ------------------------------------------------------------------
  initial clk = 1'b0;
  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (pc_load === 1'b1) begin
      load_at = n_cyc;
    end
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input int ex, input logic [11:0] got);
    n_checks++;
    if (got !== 12'(ex)) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, 12'(ex), got);
    end
  endtask

  // One instruction cycle: enable high for one clock, then low
  task automatic icyc(input logic d, t, ir, sr);
    @(negedge clk);
    cycle_en = 1'b1;
    instr_done = d;
    op_trap = t;
    op_iret = ir;
    op_sret = sr;
    n_cyc++;
    @(negedge clk);
    cycle_en = 1'b0;
    instr_done = 1'b0;
    op_trap = 1'b0;
    op_iret = 1'b0;
    op_sret = 1'b0;
  endtask

  // Boundary, then five steps; reference model decides the outcome
  task automatic bnd(input logic t, ir, sr, input logic [10:0] pc);
    int          b, src;
    logic [10:0] xp;
    logic [11:0] v;
    logic [3:0]  osp;
    logic [7:0]  lo, hi;
    src = -1;
    xp = lv;
    osp = 4'(sp);
    b = n_cyc;
    load_at = -1;
    if (ir || sr) begin
      xp = stk.pop_back();
      sp += 2;
      if (ir) g = 1;
    end else if (g != 0 && irq_v != 3'h0) begin
      src = irq_v[2] ? 3 : irq_v[1] ? 2 : 1;
      pend = pend | int'(t);
    end else if (t || pend != 0) begin
      src = 0;
      pend = 0;
    end
    if (src >= 0) begin
      v = src == 3 ? VEC_PIN : src == 2 ? VEC_WDT :
          src == 1 ? VEC_MFT : VEC_TRAP;
      lo = v[7:0] ^ 8'h3C;
      hi = (v[7:0] + 8'h01) ^ 8'h3C;
      xp = {hi[2:0], lo};
      stk.push_back(pc);
      sp -= 2;
      g = 0;
    end
    pc_in = pc;
    icyc(1'b1, t, ir, sr);
    repeat (5) icyc(1'b0, 1'b0, 1'b0, 1'b0);
    // Load pulse shows one clock after the last step
    @(negedge clk);
    lv = xp;
    chk("load_cycle", (ir || sr || src >= 0) ? b + 6 : -1, 12'(load_at));
    chk("pc_load_value", xp, pc_load_value);
    chk("stack_ptr", sp, stack_ptr);
    chk("global_mask", g, global_mask);
    if (src >= 0) begin
      chk("active_src", src, active_src);
      chk("stack_lo", pc[7:0], i_cia_mem_model.mem[{8'h03, osp}]);
      chk("stack_hi", pc[10:8], i_cia_mem_model.mem[{8'h03, osp - 4'h1}]);
    end
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {reset_n, cycle_en, instr_done, op_trap, op_iret, op_sret} = 6'h00;
    {mask_wr, mask_wdata, irq_v, pc_in} = 16'h0000;
    {op_a, op_b, x_ptr} = 28'h0;
    mode = AM_INDEXED;
    {error_cnt, n_checks, n_cyc, cyc, pend} = '0;
    g = 0;
    sp = 15;
    lv = 11'h000;
    seed = 8006;
    repeat (5) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    chk("reset_sp", 15, stack_ptr);
    chk("reset_mask", 0, global_mask);
    icyc(1'b0, 1'b0, 1'b0, 1'b0);
    bnd(1'b1, 1'b0, 1'b0, 11'($random(seed)));
    bnd(1'b0, 1'b0, 1'b1, 11'($random(seed)));
    irq_v = 3'h7;
    bnd(1'b0, 1'b0, 1'b0, 11'($random(seed)));
    @(negedge clk);
    mask_wr = 1'b1;
    mask_wdata = 1'b1;
    @(negedge clk);
    mask_wr = 1'b0;
    g = 1;
    for (int i = 1; i < 8; i++) begin
      irq_v = 3'(i);
      icyc(1'b0, 1'b0, 1'b0, 1'b0);
      chk("busy_mid_instr", 0, seq_busy);
      bnd(1'b0, 1'b0, 1'b0, 11'($random(seed)));
      irq_v = 3'h0;
      bnd(1'b0, 1'b1, 1'b0, 11'($random(seed)));
    end
    // Trap alongside a hardware request: trap waits its turn
    irq_v = 3'h4;
    bnd(1'b1, 1'b0, 1'b0, 11'($random(seed)));
    irq_v = 3'h0;
    bnd(1'b0, 1'b0, 1'b0, 11'($random(seed)));
    bnd(1'b0, 1'b1, 1'b0, 11'($random(seed)));
    bnd(1'b0, 1'b1, 1'b0, 11'($random(seed)));
    for (int i = 0; i < 28; i++) begin
      @(negedge clk);
      mode = cia_mode_t'(i % 7);
      x_ptr = 12'($random(seed));
      op_a = 8'($random(seed));
      op_b = 8'($random(seed));
      pc_in = 11'($random(seed));
      @(negedge clk);
      e = 12'h000;
      nb = 0;
      case (mode)
        AM_INDEXED: begin
          e = x_ptr[11] ? {1'b1, x_ptr[10:0] + {3'h0, op_a}}
                        : {4'h0, x_ptr[7:0] + op_a};
          nb = 1;
        end
        AM_INDIRECT:  e = {4'h0, x_ptr[7:0]};
        AM_DIRECT:    begin e = {4'h0, op_a}; nb = 1; end
        AM_IMMEDIATE: begin e = 12'h000; nb = 1; end
        AM_ABSOLUTE:  begin e = {1'b1, op_a[2:0], op_b}; nb = 2; end
        AM_RELATIVE:
          e = {1'b1, pc_in + {{5{op_a[5]}}, op_a[5:0]} + 11'h001};
        default: e = 12'h000;
      endcase
      chk("ea", e, ea);
      chk("opnd_bytes", nb, opnd_bytes);
      if (mode == AM_IMMEDIATE) chk("imm", op_a, imm);
    end
    finish_test();
  end
endmodule
